//--- glass_lcd_direct_drive.sv
// What this block does
// - Segment on when segment line opposite to common, off when equal.
// - Half-supply: polarity alternates between each common's two slot pairs so mean DC across segments is zero.
// - Refresh rate configurable, held within 30 Hz to 75 Hz.
// - One phase per common line, each selecting exactly one common.
// - Half-supply: selected common high then low, segments follow, others mid.
// - Mid-level made by releasing unselected commons to high impedance.
// - Half-supply: contrast slot after each active pulse, selected common and all segments driven high.
// - One period timer reloaded with active or contrast duration per slot.
// - Double-pulse: commons float only in the one idle cycle between refreshes; high then low pulse replaces mid-level.
// - Double-pulse: each common in turn goes low then high.
// - Double-pulse: contrast slot after each pulse pair.
// - At most four common lines supported.
// - Reference setup drives 32 segments and 4 commons.
// - At 30 Hz each half-supply slot pair is one eighth of refresh.
// - Contrast change adjusts active time so slot pair stays constant.
// - Half-supply runs 16 states per refresh, restarting after the last.
// - Contrast never zero, limited to 10% through 80% of slot pair.
// - Short trigger pulse on entering first state of each refresh.
// - Contrast defaults to about 33% of the slot pair.
// - During low common phase segments show inverted stored pattern.
// - Double-pulse: two active pulses plus contrast fill a quarter period.
//
// Purpose: APB-controlled waveform generator for a multiplexed glass LCD
// Assumes: APB slave with zero wait states; pready always high
// Notes:   Pins are three-signal; enable high means driving
`timescale 1ns/1ns
`default_nettype none
module glass_lcd_direct_drive
    import lcd_drive_pkg::*;
(
    input  wire logic                ref_clk_in,
    input  wire logic                reset_n_in,
    input  wire logic                psel_in,
    input  wire logic                penable_in,
    input  wire logic                pwrite_in,
    input  wire logic [11:0]         paddr_in,
    input  wire logic [31:0]         pwdata_in,
    output logic      [31:0]         prdata_out,
    output logic                     pready_out,
    output logic                     pslverr_out,
    output logic      [SEG_NUM-1:0]  seg_out,
    output logic      [SEG_NUM-1:0]  seg_oe_out,
    output logic      [COM_NUM-1:0]  com_out,
    output logic      [COM_NUM-1:0]  com_oe_out,
    output logic                     refresh_trigger_out
);
    import lcd_drive_pkg::*;

    // Register file
    logic [1:0]         ctrl_r, ctrl_nxt;
    logic [6:0]         contrast_r, contrast_nxt;
    logic [6:0]         refresh_r, refresh_nxt;
    logic [SEG_NUM-1:0] pattern_r [COM_NUM];
    logic [SEG_NUM-1:0] pattern_nxt [COM_NUM];
    logic [31:0]        prdata_nxt;
    logic               pslverr_nxt;

    // Sequencer state
    logic [1:0]         com_idx_r, com_idx_nxt;
    phase_t             phase_r, phase_nxt;
    logic               polarity_r, polarity_nxt;
    method_t            method_r, method_nxt;
    logic [CNT_W-1:0]   act_cyc_r, act_cyc_nxt;
    logic [CNT_W-1:0]   con_cyc_r, con_cyc_nxt;
    logic               running_r, running_nxt;
    logic [4:0]         trig_cnt_r, trig_cnt_nxt;
    logic               load;
    logic [CNT_W-1:0]   load_val;
    logic               expire;
    logic [SEG_NUM-1:0] seg_nxt, seg_oe_nxt;
    logic [COM_NUM-1:0] com_nxt, com_oe_nxt;
    logic               trig_nxt;

    logic               wr_en, rd_en;
    logic               setup_en, seg_hit;
    logic               mapped;
    logic [6:0]         pct_clip, hz_clip;
    logic [31:0]        pair_cyc, con_calc;

    assign wr_en    = psel_in && penable_in && pwrite_in;
    // Read word launched in setup; pready never waits, so it must stand in access
    assign rd_en    = psel_in && !penable_in && !pwrite_in;
    assign setup_en = psel_in && !penable_in;
    // One pattern word per common
    assign seg_hit  = (paddr_in[11:4] == OFF_SEG0[11:4]) && (paddr_in[1:0] == 2'b00);

    // Writable words only; status is read-only and stays out
    always_comb begin
        mapped = 1'b0;
        if (paddr_in == OFF_CTRL) begin
            mapped = 1'b1;
        end else if (paddr_in == OFF_CONTRAST) begin
            mapped = 1'b1;
        end else if (paddr_in == OFF_REFRESH) begin
            mapped = 1'b1;
        end else if (seg_hit) begin
            mapped = 1'b1;
        end
    end

    // Clamp settings at write time so illegal values never reach the timer
    always_comb begin
        pct_clip = pwdata_in[6:0];
        if (pwdata_in[31:7] != '0 || pwdata_in[6:0] > 7'(PCT_MAX)) begin
            pct_clip = 7'(PCT_MAX);
        end else if (pwdata_in[6:0] < 7'(PCT_MIN)) begin
            pct_clip = 7'(PCT_MIN);
        end
        hz_clip = pwdata_in[6:0];
        if (pwdata_in[31:7] != '0 || pwdata_in[6:0] > 7'(REFRESH_HZ_MAX)) begin
            hz_clip = 7'(REFRESH_HZ_MAX);
        end else if (pwdata_in[6:0] < 7'(REFRESH_HZ_MIN)) begin
            hz_clip = 7'(REFRESH_HZ_MIN);
        end
    end

    always_comb begin
        ctrl_nxt     = ctrl_r;
        contrast_nxt = contrast_r;
        refresh_nxt  = refresh_r;
        pattern_nxt  = pattern_r;
        prdata_nxt   = prdata_out;
        pslverr_nxt  = 1'b0;
        if (wr_en) begin
            if (paddr_in == OFF_CTRL) begin
                ctrl_nxt = pwdata_in[1:0];
            end else if (paddr_in == OFF_CONTRAST) begin
                contrast_nxt = pct_clip;
            end else if (paddr_in == OFF_REFRESH) begin
                refresh_nxt = hz_clip;
            end else if (seg_hit) begin
                pattern_nxt[paddr_in[3:2]] = pwdata_in;
            end
        end
        // Error raised in setup so it stands at the access edge
        if (setup_en) begin
            if (pwrite_in) begin
                pslverr_nxt = !mapped;
            end else begin
                pslverr_nxt = !mapped && (paddr_in != OFF_STATUS);
            end
        end
        if (rd_en) begin
            prdata_nxt = '0;
            if (paddr_in == OFF_CTRL) begin
                prdata_nxt[1:0] = ctrl_r;
            end else if (paddr_in == OFF_CONTRAST) begin
                prdata_nxt[6:0] = contrast_r;
            end else if (paddr_in == OFF_REFRESH) begin
                prdata_nxt[6:0] = refresh_r;
            end else if (paddr_in == OFF_STATUS) begin
                prdata_nxt = {26'h0, running_r, method_r, polarity_r, phase_r == PH_CONTR,
                              com_idx_r};
            end else if (seg_hit) begin
                prdata_nxt = pattern_r[paddr_in[3:2]];
            end
        end
    end

    // Slot pair length from refresh rate; contrast share taken from it
    always_comb begin
        if (ctrl_r[CTRL_METHOD_BIT]) begin
            pair_cyc = 32'(CLK_HZ) / (32'(refresh_r) * 32'(DBL_SLOTS));
        end else begin
            pair_cyc = 32'(CLK_HZ) / (32'(refresh_r) * 32'(HALF_SLOTS));
        end
        con_calc = (pair_cyc * 32'(contrast_r)) / 32'd100;
    end

    lcd_slot_timer u_timer (
        .clk_in     (ref_clk_in),
        .rst_n_in   (reset_n_in),
        .load_in    (load),
        .value_in   (load_val),
        .expire_out (expire)
    );

    // Slot sequencer
    always_comb begin
        com_idx_nxt  = com_idx_r;
        phase_nxt    = phase_r;
        polarity_nxt = polarity_r;
        method_nxt   = method_r;
        act_cyc_nxt  = act_cyc_r;
        con_cyc_nxt  = con_cyc_r;
        running_nxt  = running_r;
        trig_cnt_nxt = (trig_cnt_r != '0) ? trig_cnt_r - 5'd1 : 5'd0;
        load         = 1'b0;
        load_val     = act_cyc_r;
        if (!running_r) begin
            if (ctrl_r[CTRL_EN_BIT]) begin
                // Settings latched only at sequence start
                method_nxt   = method_t'(ctrl_r[CTRL_METHOD_BIT]);
                con_cyc_nxt  = con_calc[CNT_W-1:0];
                act_cyc_nxt  = CNT_W'(pair_cyc - con_calc);
                // Double pulse shares the active time between two pulses
                if (ctrl_r[CTRL_METHOD_BIT]) begin
                    act_cyc_nxt = CNT_W'((pair_cyc - con_calc) >> 1);
                end
                running_nxt  = 1'b1;
                com_idx_nxt  = '0;
                polarity_nxt = 1'b0;
                phase_nxt    = (ctrl_r[CTRL_METHOD_BIT]) ? PH_ACT_LO : PH_ACT_HI;
                load         = 1'b1;
                load_val     = act_cyc_nxt;
                trig_cnt_nxt = 5'(TRIG_CYC);
            end
        end else if (expire) begin
            load = 1'b1;
            case (phase_r)
                PH_ACT_HI: begin
                    if (method_r == METHOD_HALF) begin
                        phase_nxt = PH_CONTR;
                        load_val  = con_cyc_r;
                    end else begin
                        phase_nxt = PH_CONTR;
                        load_val  = con_cyc_r;
                    end
                end
                PH_ACT_LO: begin
                    if (method_r == METHOD_HALF) begin
                        phase_nxt = PH_CONTR;
                        load_val  = con_cyc_r;
                    end else begin
                        phase_nxt = PH_ACT_HI;
                        load_val  = act_cyc_r;
                    end
                end
                default: begin
                    // Contrast over: next common or next polarity
                    load_val = act_cyc_r;
                    if (method_r == METHOD_HALF && !polarity_r) begin
                        // Second half of the common flips polarity for zero mean DC
                        polarity_nxt = 1'b1;
                        phase_nxt    = PH_ACT_LO;
                    end else begin
                        polarity_nxt = 1'b0;
                        phase_nxt    = (method_r == METHOD_HALF) ? PH_ACT_HI : PH_ACT_LO;
                        com_idx_nxt  = com_idx_r + 2'd1;
                        if (com_idx_r == 2'(COM_NUM - 1)) begin
                            // Loop restart applies new settings
                            running_nxt = 1'b0;
                            load        = 1'b0;
                        end
                    end
                end
            endcase
        end
    end

    // Pin drive from the current slot
    always_comb begin
        seg_oe_nxt = '1;
        com_oe_nxt = '0;
        com_nxt    = '0;
        seg_nxt    = '1;
        trig_nxt   = (trig_cnt_nxt != '0);
        if (running_nxt) begin
            case (phase_nxt)
                PH_ACT_HI: begin
                    com_nxt[com_idx_nxt]    = 1'b1;
                    com_oe_nxt[com_idx_nxt] = 1'b1;
                    seg_nxt = pattern_r[com_idx_nxt];
                end
                PH_ACT_LO: begin
                    // Common low, so the pattern is mirrored in both methods
                    com_oe_nxt[com_idx_nxt] = 1'b1;
                    seg_nxt = ~pattern_r[com_idx_nxt];
                end
                default: begin
                    // Selected common and segments high bleed off the bias left by the active slot
                    com_nxt[com_idx_nxt]    = 1'b1;
                    com_oe_nxt[com_idx_nxt] = 1'b1;
                    seg_nxt = '1;
                end
            endcase
            if (method_nxt == METHOD_DOUBLE) begin
                // Unselected commons get the complementary pulse, never floating
                for (int i = 0; i < COM_NUM; i++) begin
                    if (2'(i) != com_idx_nxt) begin
                        com_oe_nxt[i] = 1'b1;
                        com_nxt[i]    = (phase_nxt == PH_ACT_LO);
                    end
                end
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            // Enable set at reset: the panel runs before software
            ctrl_r              <= CTRL_RESET;
            contrast_r          <= CONTRAST_RESET;
            refresh_r           <= REFRESH_RESET;
            for (int i = 0; i < COM_NUM; i++) begin
                pattern_r[i] <= '0;
            end
            prdata_out          <= '0;
            pready_out          <= 1'b1;
            pslverr_out         <= 1'b0;
            com_idx_r           <= '0;
            phase_r             <= PH_ACT_HI;
            polarity_r          <= 1'b0;
            method_r            <= METHOD_HALF;
            act_cyc_r           <= '0;
            con_cyc_r           <= '0;
            running_r           <= 1'b0;
            trig_cnt_r          <= '0;
            seg_out             <= '0;
            seg_oe_out          <= '0;
            com_out             <= '0;
            com_oe_out          <= '0;
            refresh_trigger_out <= 1'b0;
        end else begin
            ctrl_r              <= ctrl_nxt;
            contrast_r          <= contrast_nxt;
            refresh_r           <= refresh_nxt;
            pattern_r           <= pattern_nxt;
            prdata_out          <= prdata_nxt;
            pready_out          <= 1'b1;
            pslverr_out         <= pslverr_nxt;
            com_idx_r           <= com_idx_nxt;
            phase_r             <= phase_nxt;
            polarity_r          <= polarity_nxt;
            method_r            <= method_nxt;
            act_cyc_r           <= act_cyc_nxt;
            con_cyc_r           <= con_cyc_nxt;
            running_r           <= running_nxt;
            trig_cnt_r          <= trig_cnt_nxt;
            seg_out             <= seg_nxt;
            seg_oe_out          <= seg_oe_nxt;
            com_out             <= com_nxt;
            com_oe_out          <= com_oe_nxt;
            refresh_trigger_out <= trig_nxt;
        end
    end
endmodule
`default_nettype wire

//--- lcd_drive_pkg.sv
// Purpose: Shared constants and types for the direct-drive glass LCD block
// Assumes: 25 MHz system clock
// Notes:   Times in their own units, cycle counts derived from them
package lcd_drive_pkg;
    localparam int          SEG_NUM          = 32;
    localparam int          COM_NUM          = 4;
    localparam int          CLK_HZ           = 25000000;
    localparam int          REFRESH_HZ_MIN   = 30;
    localparam int          REFRESH_HZ_MAX   = 75;
    localparam int          REFRESH_HZ_DEF   = 30;
    localparam int          PCT_MIN          = 10;
    localparam int          PCT_MAX          = 80;
    localparam int          PCT_DEF          = 33;
    localparam int          HALF_SLOTS       = 8;
    localparam int          DBL_SLOTS        = 4;
    localparam int          TRIG_CYC         = 16;
    localparam int          CNT_W            = 24;
    localparam logic [11:0] OFF_CTRL         = 12'h000;
    localparam logic [11:0] OFF_CONTRAST     = 12'h004;
    localparam logic [11:0] OFF_REFRESH      = 12'h008;
    localparam logic [11:0] OFF_STATUS       = 12'h00c;
    localparam logic [11:0] OFF_SEG0         = 12'h010;
    localparam int          CTRL_EN_BIT      = 0;
    localparam int          CTRL_METHOD_BIT  = 1;
    localparam logic [6:0]  CONTRAST_RESET   = 7'(PCT_DEF);
    localparam logic [6:0]  REFRESH_RESET    = 7'(REFRESH_HZ_DEF);
    localparam logic [1:0]  CTRL_RESET       = 2'h1;
    typedef enum logic [0:0] {
        METHOD_HALF   = 1'b0,
        METHOD_DOUBLE = 1'b1
    } method_t;
    typedef enum logic [1:0] {
        PH_ACT_HI  = 2'b00,
        PH_ACT_LO  = 2'b01,
        PH_CONTR   = 2'b10
    } phase_t;
endpackage

//--- lcd_slot_timer.sv
// Purpose: Reloadable period timer shared by active and contrast slots
// Assumes: Load has priority over counting
// Notes:   Expire is a one-cycle pulse when the count reaches one
`timescale 1ns/1ns
`default_nettype none
module lcd_slot_timer
    import lcd_drive_pkg::*;
(
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    input  wire logic             load_in,
    input  wire logic [CNT_W-1:0] value_in,
    output logic                  expire_out
);
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;

    always_comb begin
        if (load_in) begin
            cnt_nxt = value_in;
        end else if (cnt_r != '0) begin
            cnt_nxt = cnt_r - 1'b1;
        end else begin
            cnt_nxt = cnt_r;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    // Not gated by load: the reload itself follows expire
    assign expire_out = (cnt_r == {{(CNT_W-1){1'b0}}, 1'b1});
endmodule
`default_nettype wire

//--- lcd_drive_chk.sv
// Purpose: Port checker for the glass LCD direct-drive block
// Assumes: One clock, asynchronous active-low reset
// Notes:   Hold window is far shorter than any slot
`timescale 1ns/1ns
`default_nettype none
module lcd_drive_chk
    import lcd_drive_pkg::*;
(
    input  wire logic               ref_clk_in,
    input  wire logic               reset_n_in,
    input  wire logic               psel_in,
    input  wire logic               penable_in,
    input  wire logic               pwrite_in,
    input  wire logic [11:0]        paddr_in,
    input  wire logic [31:0]        pwdata_in,
    input  wire logic [31:0]        prdata_out,
    input  wire logic               pready_out,
    input  wire logic               pslverr_out,
    input  wire logic [SEG_NUM-1:0] seg_out,
    input  wire logic [SEG_NUM-1:0] seg_oe_out,
    input  wire logic [COM_NUM-1:0] com_out,
    input  wire logic [COM_NUM-1:0] com_oe_out,
    input  wire logic               refresh_trigger_out
);
    logic [4:0] trig_cnt_r;
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!reset_n_in);
    // Length of the current trigger pulse so far
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            trig_cnt_r <= 5'h0;
        end else begin
            trig_cnt_r <= refresh_trigger_out ? trig_cnt_r + 5'h1 : 5'h0;
        end
    end
    property p_trig_len; $fell(refresh_trigger_out) |-> trig_cnt_r == TRIG_CYC; endproperty
    a_trig_len: assert property (p_trig_len) else $error("trigger pulse length wrong");
    property p_trig_max; refresh_trigger_out |-> trig_cnt_r < TRIG_CYC; endproperty
    a_trig_max: assert property (p_trig_max) else $error("trigger pulse too long");
    property p_trig_com0; $rose(refresh_trigger_out) |-> ##[0:3] com_oe_out[0]; endproperty
    a_trig_com0: assert property (p_trig_com0) else $error("sequence not at first common");
    property p_com_sel; $onehot0(com_oe_out) || (com_oe_out == '1); endproperty
    a_com_sel: assert property (p_com_sel) else $error("common selection illegal");
    property p_dbl_comp;
        (com_oe_out == '1) |-> ($onehot(com_out) || $onehot(~com_out));
    endproperty
    a_dbl_comp: assert property (p_dbl_comp) else $error("driven commons not one apart");
    property p_seg_oe; $past(reset_n_in) |-> seg_oe_out == '1; endproperty
    a_seg_oe: assert property (p_seg_oe) else $error("segment partly floated");
    // Idle restart cycle sits under the trigger pulse
    property p_slot_hold;
        $changed(com_oe_out) |=> (refresh_trigger_out || $stable(com_oe_out)) [*8];
    endproperty
    a_slot_hold: assert property (p_slot_hold) else $error("slot shorter than timer");
    property p_err_ro;
        (psel_in && penable_in && pwrite_in && paddr_in == OFF_STATUS) |-> pslverr_out;
    endproperty
    a_err_ro: assert property (p_err_ro) else $error("status write not refused");
    property p_err_cause; pslverr_out |-> psel_in && penable_in; endproperty
    a_err_cause: assert property (p_err_cause) else $error("error without access");
    property p_ready; pready_out; endproperty
    a_ready: assert property (p_ready) else $error("ready dropped");
    c_trig: cover property ($rose(refresh_trigger_out));
    c_contr: cover property (com_oe_out[0] && seg_out == '1);
    c_err: cover property (pslverr_out);
endmodule
bind glass_lcd_direct_drive lcd_drive_chk lcd_drive_chk_inst (
    .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .seg_out(seg_out), .seg_oe_out(seg_oe_out),
    .com_out(com_out), .com_oe_out(com_oe_out), .refresh_trigger_out(refresh_trigger_out));
`default_nettype wire

//--- lcd_glass_model.sv
// Purpose: Passive multiplexed glass panel seen from its pins
// Assumes: Equal divider resistors on every common
// Notes:   Reports lit segments of the first common only
`timescale 1ns/1ns
`default_nettype none
module lcd_glass_model
    import lcd_drive_pkg::*;
(
    input  wire logic [SEG_NUM-1:0] seg_in,
    input  wire logic [SEG_NUM-1:0] seg_oe_in,
    input  wire logic [COM_NUM-1:0] com_in,
    input  wire logic [COM_NUM-1:0] com_oe_in,
    output logic      [SEG_NUM-1:0] lit0_out,
    output logic      [COM_NUM-1:0] mid_out
);
    // Floated common rests at the divider midpoint
    assign mid_out = ~com_oe_in;
    // Lit only where a driven segment opposes a driven common
    assign lit0_out = seg_oe_in & {SEG_NUM{com_oe_in[0]}} & (seg_in ^ {SEG_NUM{com_in[0]}});
endmodule
`default_nettype wire

//--- glass_lcd_direct_drive_tb.sv
// Purpose: Self-checking bench for the glass LCD direct-drive block
// Assumes: Default 30 Hz refresh, so only the first slots fit the run
// Notes:   Settings written mid-refresh must not alter the running slots
`timescale 1ns/1ns
`default_nettype none
module glass_lcd_direct_drive_tb;
    import lcd_drive_pkg::*;
    localparam int PAIR = CLK_HZ / (REFRESH_HZ_DEF * HALF_SLOTS);
    localparam int CON = PAIR * PCT_DEF / 100;
    localparam int ACT = PAIR - CON;
    localparam int LIMIT = 110000;
    localparam logic [31:0] PAT = 32'ha5c3_0f01;
    localparam logic [11:0] CA[5] = '{OFF_CONTRAST, OFF_CONTRAST, OFF_CONTRAST,
                                      OFF_REFRESH, OFF_REFRESH};
    localparam logic [31:0] CW[5] = '{32'h5, 32'h5a, 32'h2d, 32'h14, 32'h64};
    localparam logic [31:0] CE[5] = '{32'ha, 32'h50, 32'h2d, 32'h1e, 32'h4b};
    logic               clk = 1'b0;
    logic               rst_n = 1'b0;
    logic               psel = 1'b0;
    logic               penable = 1'b0;
    logic               pwrite = 1'b0;
    logic [11:0]        paddr = 12'h0;
    logic [31:0]        pwdata = 32'h0;
    logic [31:0]        prdata, q;
    logic               pready, pslverr, e;
    logic [SEG_NUM-1:0] seg, seg_oe, lit0;
    logic [COM_NUM-1:0] com, com_oe, mid;
    logic               trig;
    int                 fails = 0, tests_run = 0, cyc = 0, t0, t1, t2, n;
    glass_lcd_direct_drive glass_lcd_direct_drive_inst (
        .ref_clk_in(clk), .reset_n_in(rst_n), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .seg_out(seg), .seg_oe_out(seg_oe),
        .com_out(com), .com_oe_out(com_oe), .refresh_trigger_out(trig));
    lcd_glass_model lcd_glass_model_inst (
        .seg_in(seg), .seg_oe_in(seg_oe), .com_in(com), .com_oe_in(com_oe),
        .lit0_out(lit0), .mid_out(mid));
    always #20 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc >= LIMIT) begin
            fails++;
            end_sim();
        end
    end
    task end_sim;
        $display("counts: tests_run=%0d fails=%0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task chk(input bit ok, input string m);
        tests_run++;
        if (!ok) begin
            fails++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask
    // Request held until the edge that samples pready high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Read at the edge itself: values launched before it, as the slave sees them
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task t_start;
        for (n = 0; n < 50 && com_oe !== 4'h1; n++) begin
            @(posedge clk);
            #1;
        end
        t0 = cyc;
        chk(trig === 1'b1, "no trigger at start");
        chk(com[0] === 1'b1, "first slot not high");
        chk(mid === 4'he, "unselected commons driven");
        apb(1'b1, OFF_SEG0, PAT);
        @(posedge clk);
        #1;
        chk(seg === PAT, "active high pattern");
        chk(lit0 === ~PAT, "lit segments");
        chk(seg_oe === '1, "segments floated");
        $display("test start done");
    endtask
    task t_regs;
        apb(1'b0, OFF_CTRL, 32'h0);
        chk(q === 32'(CTRL_RESET) && e === 1'b0, "ctrl reset");
        apb(1'b0, OFF_CONTRAST, 32'h0);
        chk(q === 32'(CONTRAST_RESET), "contrast reset");
        apb(1'b0, OFF_REFRESH, 32'h0);
        chk(q === 32'(REFRESH_RESET), "refresh reset");
        $display("test regs done");
    endtask
    task t_clamp;
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, CA[i], CW[i]);
            apb(1'b0, CA[i], 32'h0);
            chk(q === CE[i], "setting clamp");
        end
        apb(1'b1, OFF_CTRL, 32'h3);
        apb(1'b0, OFF_CTRL, 32'h0);
        chk(q === 32'h3, "method select");
        $display("test clamp done");
    endtask
    task t_refused;
        apb(1'b1, OFF_STATUS, 32'h0);
        chk(e === 1'b1, "status write accepted");
        apb(1'b0, 12'h100, 32'h0);
        chk(e === 1'b1, "unmapped read accepted");
        apb(1'b0, OFF_STATUS, 32'h0);
        chk(e === 1'b0, "status read refused");
        $display("test refused done");
    endtask
    task t_timing;
        for (n = 0; n < PAIR && seg !== '1; n++) begin
            @(posedge clk);
            #1;
        end
        t1 = cyc;
        chk(t1 - t0 >= ACT - 2 && t1 - t0 <= ACT + 2, "active length");
        chk(com[0] === 1'b1 && com_oe === 4'h1, "contrast common");
        for (n = 0; n < PAIR && com[0] !== 1'b0; n++) begin
            @(posedge clk);
            #1;
        end
        t2 = cyc;
        chk(t2 - t1 >= CON - 2 && t2 - t1 <= CON + 2, "contrast length");
        chk(seg === ~PAT, "inverted pattern");
        chk(com_oe === 4'h1, "method changed mid refresh");
        chk(lit0 === ~PAT, "polarity swap");
        $display("test timing done");
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        t_start();
        t_regs();
        t_clamp();
        t_refused();
        t_timing();
        end_sim();
    end
endmodule
`default_nettype wire
